// >>> common/sld_pkg.sv
package sld_pkg;

    // Time base
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int unsigned TICK_W = 16;

    // Pattern phase lengths in milliseconds
    localparam int unsigned FLASH_MS = 200;
    localparam int unsigned PAUSE_MS = 1000;
    localparam int unsigned FLICK_MS = 50;
    localparam int unsigned MS_W = 11;

    localparam int unsigned PORTS = 2;

    // Slave state encoding on the state input
    typedef enum logic [1:0] {
        SLD_ST_INIT = 2'h0,
        SLD_ST_PREOP = 2'h1,
        SLD_ST_SAFEOP = 2'h3,
        SLD_ST_OP = 2'h2
    } sld_state_t;

    // Fault conditions from the protocol logic
    typedef struct packed {
        logic bad_config;
        logic local_change;
        logic sync_error;
        logic app_watchdog;
    } sld_fault_t;

    // Per-port link information
    typedef struct packed {
        logic link;
        logic frame;
    } sld_port_t;

    // Pattern sequencer phases, Gray along the double-flash path except the return from SLD_PH_PAUSE to SLD_PH_LIT1
    typedef enum logic [2:0] {
        SLD_PH_DARK = 3'h0,
        SLD_PH_LIT1 = 3'h1,
        SLD_PH_GAP = 3'h3,
        SLD_PH_LIT2 = 3'h2,
        SLD_PH_PAUSE = 3'h6
    } sld_phase_t;

    typedef enum logic [1:0] {
        SLD_PAT_OFF = 2'h0,
        SLD_PAT_BLINK = 2'h1,
        SLD_PAT_SINGLE = 2'h3,
        SLD_PAT_DOUBLE = 2'h2
    } sld_pattern_t;

endpackage

// >>> design/sld_led_driver.sv
`timescale 1ns/1ps
module sld_led_driver
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Protocol state
    input wire sld_pkg::sld_state_t state_in,
    input wire sld_pkg::sld_fault_t fault_in,
    // Ports
    input wire sld_pkg::sld_port_t [sld_pkg::PORTS-1:0] port_in,
    // Indicators
    output logic run_green_out,
    output logic err_red_out,
    output logic [sld_pkg::PORTS-1:0] port_green_out,
    output logic [sld_pkg::PORTS-1:0] port_yellow_out,
    output logic force_safeop_out
);

    logic [sld_pkg::TICK_W-1:0] div;
    logic [sld_pkg::TICK_W-1:0] next_div;
    logic tick;
    logic next_tick;
    logic force_safeop;
    logic next_force_safeop;
    sld_pkg::sld_pattern_t run_pat;
    sld_pkg::sld_pattern_t err_pat;
    logic run_steady;

    // Millisecond time base shared by every pattern
    always_comb
    begin
        next_tick = 1'b0;
        next_div = div + 1'b1;
        if (div == sld_pkg::TICK_W'(sld_pkg::TICK_CYCLES - 1))
        begin
            next_div = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div <= '0;
            tick <= 1'b0;
        end
        else
        begin
            div <= next_div;
            tick <= next_tick;
        end
    end

    // A sync error is held as a request until the state logic reports inputs-only
    always_comb
    begin
        next_force_safeop = force_safeop;
        if (fault_in.sync_error)
            next_force_safeop = 1'b1;
        else if (state_in == sld_pkg::SLD_ST_SAFEOP)
            next_force_safeop = 1'b0;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            force_safeop <= 1'b0;
        else
            force_safeop <= next_force_safeop;
    end

    assign force_safeop_out = force_safeop;

    // Pattern selection; the most severe fault wins on the red indicator
    always_comb
    begin
        run_steady = 1'b0;
        unique case (state_in)
            sld_pkg::SLD_ST_INIT: run_pat = sld_pkg::SLD_PAT_OFF;
            sld_pkg::SLD_ST_PREOP: run_pat = sld_pkg::SLD_PAT_BLINK;
            sld_pkg::SLD_ST_SAFEOP: run_pat = sld_pkg::SLD_PAT_SINGLE;
            sld_pkg::SLD_ST_OP:
            begin
                run_pat = sld_pkg::SLD_PAT_OFF;
                run_steady = 1'b1;
            end
        endcase
        if (fault_in.app_watchdog)
            err_pat = sld_pkg::SLD_PAT_DOUBLE;
        else if (fault_in.local_change || fault_in.sync_error || force_safeop)
            err_pat = sld_pkg::SLD_PAT_SINGLE;
        else if (fault_in.bad_config)
            err_pat = sld_pkg::SLD_PAT_BLINK;
        else
            err_pat = sld_pkg::SLD_PAT_OFF;
    end

    sld_pattern u_run
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .pattern_in(run_pat),
        .steady_in(run_steady),
        .lit_out(run_green_out)
    );

    sld_pattern u_err
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .pattern_in(err_pat),
        .steady_in(1'b0),
        .lit_out(err_red_out)
    );

    // Link/activity: a frame starts a 50 ms dark blip then 50 ms lit hold,
    // so sparse frames give irregular blinks and heavy load gives about 10 Hz
    logic [sld_pkg::PORTS-1:0][6:0] act_ms;
    logic [sld_pkg::PORTS-1:0][6:0] next_act_ms;
    logic [sld_pkg::PORTS-1:0] next_green;

    always_comb
    begin
        for (int p = 0; p < sld_pkg::PORTS; p++)
        begin
            next_act_ms[p] = act_ms[p];
            if (!port_in[p].link)
                next_act_ms[p] = '0;
            else if (act_ms[p] != 7'h00)
            begin
                if (tick)
                    next_act_ms[p] = act_ms[p] - 7'h01;
            end
            else if (port_in[p].frame)
                next_act_ms[p] = 7'(2 * sld_pkg::FLICK_MS);
            // Dark in the first half of the window or without link, lit otherwise
            next_green[p] = port_in[p].link &&
                            (act_ms[p] <= 7'(sld_pkg::FLICK_MS));
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_ms <= '0;
            port_green_out <= '0;
            port_yellow_out <= '0;
        end
        else
        begin
            act_ms <= next_act_ms;
            port_green_out <= next_green;
            port_yellow_out <= '0;
        end
    end

endmodule // sld_led_driver

// >>> design/sld_pattern.sv
`timescale 1ns/1ps
// One indicator pattern sequencer, stepping on the millisecond tick
module sld_pattern
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Control
    input wire logic tick_in,
    input wire sld_pkg::sld_pattern_t pattern_in,
    input wire logic steady_in,
    // Indicator
    output logic lit_out
);

    sld_pkg::sld_phase_t phase;
    sld_pkg::sld_phase_t next_phase;
    sld_pkg::sld_pattern_t last_pattern;
    logic [sld_pkg::MS_W-1:0] ms;
    logic [sld_pkg::MS_W-1:0] next_ms;
    logic next_lit;
    logic [sld_pkg::MS_W-1:0] limit;

    always_comb
    begin
        next_phase = phase;
        next_ms = ms;
        limit = (phase == sld_pkg::SLD_PH_PAUSE) ? sld_pkg::MS_W'(sld_pkg::PAUSE_MS)
                                                 : sld_pkg::MS_W'(sld_pkg::FLASH_MS);
        // A changed pattern restarts from dark so no stray half-phase shows
        if (pattern_in != last_pattern || pattern_in == sld_pkg::SLD_PAT_OFF)
        begin
            next_phase = sld_pkg::SLD_PH_DARK;
            next_ms = '0;
        end
        else if (tick_in)
        begin
            if (ms + 1'b1 >= limit)
            begin
                next_ms = '0;
                unique case (phase)
                    sld_pkg::SLD_PH_DARK: next_phase = sld_pkg::SLD_PH_LIT1;
                    sld_pkg::SLD_PH_LIT1:
                        next_phase = (pattern_in == sld_pkg::SLD_PAT_BLINK) ?
                                     sld_pkg::SLD_PH_DARK :
                                     (pattern_in == sld_pkg::SLD_PAT_DOUBLE) ?
                                     sld_pkg::SLD_PH_GAP : sld_pkg::SLD_PH_PAUSE;
                    sld_pkg::SLD_PH_GAP: next_phase = sld_pkg::SLD_PH_LIT2;
                    sld_pkg::SLD_PH_LIT2: next_phase = sld_pkg::SLD_PH_PAUSE;
                    sld_pkg::SLD_PH_PAUSE: next_phase = sld_pkg::SLD_PH_LIT1;
                    default: next_phase = sld_pkg::SLD_PH_DARK;
                endcase
            end
            else
            begin
                next_ms = ms + 1'b1;
            end
        end
        next_lit = steady_in ||
                   (phase == sld_pkg::SLD_PH_LIT1 || phase == sld_pkg::SLD_PH_LIT2);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase <= sld_pkg::SLD_PH_DARK;
            ms <= '0;
            last_pattern <= sld_pkg::SLD_PAT_OFF;
            lit_out <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            ms <= next_ms;
            last_pattern <= pattern_in;
            lit_out <= next_lit;
        end
    end

endmodule // sld_pattern

// >>> verif/sld_led_driver_chk.sv
`timescale 1ns/1ps
module sld_led_driver_chk
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Protocol state and port links
    input wire sld_pkg::sld_state_t state_in,
    input wire sld_pkg::sld_fault_t fault_in,
    input wire sld_pkg::sld_port_t [sld_pkg::PORTS-1:0] port_in,
    // Indicators
    input wire logic run_green_out,
    input wire logic err_red_out,
    input wire logic [sld_pkg::PORTS-1:0] port_green_out,
    input wire logic [sld_pkg::PORTS-1:0] port_yellow_out,
    input wire logic force_safeop_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // A pattern entered less than one phase ago must still be dark
    sequence s_new(sld_pkg::sld_state_t s);
        (state_in != s) ##1 (state_in == s) [*8];
    endsequence
    sequence s_held(sld_pkg::sld_state_t s);
        (state_in == s) [*4];
    endsequence
    sequence s_quiet;
        (fault_in == '0 && !force_safeop_out) [*4];
    endsequence
    property p_force_hold;
        force_safeop_out && state_in != sld_pkg::SLD_ST_SAFEOP |=> force_safeop_out;
    endproperty
    a_init_dark: assert property (s_held(sld_pkg::SLD_ST_INIT) |=> !run_green_out)
        else $error("green lit in startup state");
    a_preop_dark: assert property (s_new(sld_pkg::SLD_ST_PREOP) |-> !run_green_out)
        else $error("blink did not start dark");
    a_safeop_dark: assert property (s_new(sld_pkg::SLD_ST_SAFEOP) |-> !run_green_out)
        else $error("single flash did not start dark");
    a_op_lit: assert property (s_held(sld_pkg::SLD_ST_OP) |=> run_green_out)
        else $error("green not steady in operational");
    a_red_dark: assert property (s_quiet |=> !err_red_out)
        else $error("red lit without fault");
    a_yellow_off: assert property (port_yellow_out == '0)
        else $error("yellow indicator lit");
    a_sync_force: assert property (fault_in.sync_error |-> ##[1:2] force_safeop_out)
        else $error("sync error did not force inputs-only");
    a_force_hold: assert property (p_force_hold)
        else $error("force request dropped early");
    for (genvar i = 0; i < sld_pkg::PORTS; i++)
    begin : g_port
        property p_own_link;
            $rose(port_green_out[i]) |-> $past(port_in[i].link);
        endproperty
        a_link_dark: assert property (!port_in[i].link [*4] |=> !port_green_out[i])
            else $error("port green lit without link");
        a_link_lit: assert property (p_own_link)
            else $error("port green rose without own link");
        a_link_steady: assert property ($rose(port_in[i].link) |=> port_green_out[i])
            else $error("port green not lit on new link");
    end
endmodule // sld_led_driver_chk

bind sld_led_driver sld_led_driver_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .state_in(state_in), .fault_in(fault_in), .port_in(port_in), .run_green_out(run_green_out),
    .err_red_out(err_red_out), .port_green_out(port_green_out),
    .port_yellow_out(port_yellow_out), .force_safeop_out(force_safeop_out));

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_in;
    logic rst_in;
    sld_pkg::sld_state_t state_in;
    sld_pkg::sld_fault_t fault_in;
    sld_pkg::sld_port_t [sld_pkg::PORTS-1:0] port_in;
    logic run_green_out;
    logic err_red_out;
    logic [sld_pkg::PORTS-1:0] port_green_out;
    logic [sld_pkg::PORTS-1:0] port_yellow_out;
    logic force_safeop_out;
    int errors;
    int n_checks;
    sld_led_driver DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .state_in(state_in),
        .fault_in(fault_in), .port_in(port_in), .run_green_out(run_green_out),
        .err_red_out(err_red_out), .port_green_out(port_green_out),
        .port_yellow_out(port_yellow_out), .force_safeop_out(force_safeop_out));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        chk(run_green_out | err_red_out | force_safeop_out, 1'b0);
        chk(|{port_green_out, port_yellow_out}, 1'b0);
    endtask
    // Each state stands long enough for the checker's start-dark sequences to match
    task automatic t_run();
        sld_pkg::sld_state_t st [4] = '{sld_pkg::SLD_ST_INIT, sld_pkg::SLD_ST_PREOP,
            sld_pkg::SLD_ST_SAFEOP, sld_pkg::SLD_ST_OP};
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk_sys_in);
            state_in <= st[k % 4 + k / 4];
            settle(9);
            chk(run_green_out, k == 3);
        end
    endtask
    task automatic t_red();
        @(posedge clk_sys_in);
        state_in <= sld_pkg::SLD_ST_OP;
        settle(4);
        chk(err_red_out, 1'b0);
        @(posedge clk_sys_in);
        fault_in.sync_error <= 1'b1;
        settle(3);
        chk(force_safeop_out, 1'b1);
        @(posedge clk_sys_in);
        fault_in.sync_error <= 1'b0;
        settle(5);
        chk(force_safeop_out, 1'b1);
        @(posedge clk_sys_in);
        state_in <= sld_pkg::SLD_ST_SAFEOP;
        settle(4);
        chk(force_safeop_out, 1'b0);
        // Every fault pattern must begin in its dark phase
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys_in);
            fault_in <= sld_pkg::sld_fault_t'(4'h1 << k);
            settle(3);
            chk(err_red_out, 1'b0);
        end
        @(posedge clk_sys_in);
        fault_in <= '0;
    endtask
    task automatic t_port(input int i);
        @(posedge clk_sys_in);
        port_in[i].link <= 1'b1;
        settle(3);
        chk(port_green_out[i], 1'b1);
        chk(port_green_out[1-i], 1'b0);
        @(posedge clk_sys_in);
        port_in[i].frame <= 1'b1;
        @(posedge clk_sys_in);
        port_in[i].frame <= 1'b0;
        settle(3);
        chk(port_green_out[i], 1'b0);
        chk(port_green_out[1-i], 1'b0);
        settle(1000);
        chk(port_green_out[i], 1'b0);
        chk(|port_yellow_out, 1'b0);
        @(posedge clk_sys_in);
        port_in[i].link <= 1'b0;
        settle(3);
        chk(port_green_out[i], 1'b0);
        // Losing the link must also drop the pending dark window
        @(posedge clk_sys_in);
        port_in[i].link <= 1'b1;
        settle(3);
        chk(port_green_out[i], 1'b1);
        @(posedge clk_sys_in);
        port_in[i].link <= 1'b0;
        settle(3);
        chk(port_green_out[i], 1'b0);
    endtask
    // Reset in mid-run clears the force request and restarts the indicators
    task automatic t_rerun();
        @(posedge clk_sys_in);
        state_in <= sld_pkg::SLD_ST_OP;
        fault_in.sync_error <= 1'b1;
        settle(3);
        chk(run_green_out & force_safeop_out, 1'b1);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        fault_in.sync_error <= 1'b0;
        settle(2);
        chk(run_green_out | err_red_out | force_safeop_out, 1'b0);
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        settle(2);
        chk(run_green_out, 1'b1);
        chk(force_safeop_out | err_red_out, 1'b0);
    endtask
    initial
    begin
        errors = 0;
        n_checks = 0;
        rst_in = 1'b1;
        state_in = sld_pkg::SLD_ST_INIT;
        fault_in = '0;
        port_in = '0;
        settle(11);
        t_reset();
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_run();
        t_red();
        t_port(0);
        t_port(1);
        t_rerun();
        close_out();
    end
    initial
    begin
        #400000;
        errors++;
        close_out();
    end
endmodule // tb_top
